// ### design/uims_pkg.sv
// Shared constants and carriers for the serial port interrupt mask and status block.
package uims_pkg;

	// Register bus shape.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;

	// Number of interrupt sources and the first reserved bit above them.
	localparam int SRC_N = 11;
	localparam int RSVD_LSB = 11;

	// Byte offsets of the four interrupt registers.
	localparam logic [11:0] OFS_ENABLE_MASK = 12'h038;
	localparam logic [11:0] OFS_UNMASKED_STATE = 12'h03C;
	localparam logic [11:0] OFS_MASKED_STATE = 12'h040;
	localparam logic [11:0] OFS_INT_CLEAR = 12'h044;

	// Bit positions of the sources, shared by all four registers.
	localparam int BIT_OVERRUN = 10;
	localparam int BIT_BREAK = 9;
	localparam int BIT_PARITY = 8;
	localparam int BIT_FRAMING = 7;
	localparam int BIT_RX_TIMEOUT = 6;
	localparam int BIT_TX_LEVEL = 5;
	localparam int BIT_RX_LEVEL = 4;
	localparam int BIT_SET_READY = 3;
	localparam int BIT_CARRIER = 2;
	localparam int BIT_CLEAR_TO_SEND = 1;
	localparam int BIT_RING = 0;

	// Values after reset.
	localparam logic [10:0] MASK_RST = 11'h000;
	localparam logic [10:0] RAW_RST = 11'h000;
	localparam logic [3:0] MODEM_IDLE_N = 4'hF;
	localparam logic [15:0] RDATA_RST = 16'h0000;

	// Default receive and transmit FIFO depth.
	localparam int FIFO_DEPTH_DEF = 32;

	// One bit per source, in register order from bit 10 down to bit 0.
	typedef struct packed {
		logic overrun;
		logic break_err;
		logic parity;
		logic framing;
		logic rx_timeout;
		logic tx_level;
		logic rx_level;
		logic set_ready;
		logic carrier;
		logic clear_to_send;
		logic ring;
	} uims_src_s;

	// Error and timeout events reported by the receive path.
	typedef struct packed {
		logic overrun;
		logic break_err;
		logic parity;
		logic framing;
		logic rx_timeout;
	} uims_err_s;

	// The four active-low modem status inputs.
	typedef struct packed {
		logic set_ready_n_in;
		logic carrier_detect_n_in;
		logic clear_to_send_n_in;
		logic ring_indicator_n_in;
	} uims_modem_s;

endpackage : uims_pkg

// ### design/uims_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a group of asynchronous levels.
module uims_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	// Each bit gets its own pair of flops; the first is read only by the second.
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		logic meta_r;
		logic hold_r;

		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				meta_r <= RST_VAL[i];
				hold_r <= RST_VAL[i];
			end
			else
			begin
				meta_r <= async_i[i];
				hold_r <= meta_r;
			end
		end

		assign sync_o[i] = hold_r;
	end

endmodule : uims_sync

// ### design/uims_cross.sv
`timescale 1ns/1ns
// Detects the fill level of a FIFO passing through its trigger level.
module uims_cross #(
	parameter int FILL_W = 6,
	parameter bit FALLING = 1'b0,
	parameter bit PREV_RST = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [FILL_W-1:0] fill_i,
	input wire logic [FILL_W-1:0] trigger_i,
	output logic cross_o
);

	logic reached;
	logic reached_r;

	// A falling detector wants the level at or below the trigger, a rising one at or above.
	always_comb
	begin
		if (FALLING)
			reached = (fill_i <= trigger_i);
		else
			reached = (fill_i >= trigger_i);
	end

	// Remember the last comparison so that only the passage itself is reported.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reached_r <= PREV_RST;
		else
			reached_r <= reached;
	end

	// A level that sits beyond the trigger raises nothing after its first cycle.
	assign cross_o = reached & ~reached_r;

endmodule : uims_cross

// ### design/uims_top.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
// Functional notes
// - Mask bits written directly, read back current.
// - Reset clears every mask bit.
// - Mask bits: overrun 10 down to ring 0.
// - Reserved bits 15:11 read zero, left alone.
// - Raw status read-only, writes ignored.
// - Raw status resets non-modem bits to zero.
// - Raw status uses the mask bit layout.
// - Masked status read-only, same layout.
// - Masked status non-modem bits read zero after reset.
// - Clear register write-only, one clears, zero ignored.
// - Clear bits map like the status bits.
// - Four modem inputs, each its own source.
// - FIFO interrupts fire on passing the trigger.
module uims_top #(
	parameter int FIFO_DEPTH = uims_pkg::FIFO_DEPTH_DEF,
	parameter int FILL_W = $clog2(FIFO_DEPTH + 1)
) (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [uims_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [uims_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [uims_pkg::DATA_W-1:0] RDATA_O,
	input wire uims_pkg::uims_err_s ERR_EVENT_I,
	input wire logic [FILL_W-1:0] TX_FILL_I,
	input wire logic [FILL_W-1:0] TX_TRIGGER_I,
	input wire logic [FILL_W-1:0] RX_FILL_I,
	input wire logic [FILL_W-1:0] RX_TRIGGER_I,
	input wire uims_pkg::uims_modem_s MODEM_N_I,
	output uims_pkg::uims_src_s IRQ_O,
	output logic INTR_O
);

	// A FIFO of one entry has no level to pass through, and the fill count must fit.
	if (FIFO_DEPTH < 2)
	begin : g_bad_depth
		$error("uims_top: FIFO_DEPTH must be at least 2");
	end
	if (FILL_W < $clog2(FIFO_DEPTH + 1))
	begin : g_bad_fill
		$error("uims_top: FILL_W too narrow for FIFO_DEPTH");
	end

	// The source struct, the reserved field and the bus width must agree. Otherwise the
	// read multiplexer and the clear decode would shift bits out of place.
	if ($bits(uims_pkg::uims_src_s) != uims_pkg::SRC_N)
	begin : g_bad_src
		$error("uims_top: source struct width differs from SRC_N");
	end
	if (uims_pkg::RSVD_LSB != uims_pkg::SRC_N)
	begin : g_bad_rsvd
		$error("uims_top: reserved field must start just above the sources");
	end
	if (uims_pkg::DATA_W != uims_pkg::SRC_N + 5)
	begin : g_bad_data
		$error("uims_top: read data must be the sources plus five reserved bits");
	end

	// Register state and its next values.
	uims_pkg::uims_src_s interrupt_enable_mask_r;
	uims_pkg::uims_src_s interrupt_enable_mask_nxt;
	uims_pkg::uims_src_s unmasked_interrupt_state_r;
	uims_pkg::uims_src_s unmasked_interrupt_state_nxt;
	uims_pkg::uims_src_s masked_irq_r;
	uims_pkg::uims_src_s masked_irq_nxt;
	logic intr_r;
	logic intr_nxt;
	logic [uims_pkg::DATA_W-1:0] rdata_r;
	logic [uims_pkg::DATA_W-1:0] rdata_nxt;

	// Decoded bus accesses.
	logic wr_mask;
	logic wr_clear;
	logic rd_mask;
	logic rd_raw;
	logic rd_masked;

	// Per-source set and clear requests for this cycle.
	uims_pkg::uims_src_s src_event;
	uims_pkg::uims_src_s interrupt_clear;

	// Modem input path.
	uims_pkg::uims_modem_s modem_sync;
	uims_pkg::uims_modem_s modem_prev_r;
	uims_pkg::uims_modem_s modem_change;

	// FIFO level passage events.
	logic tx_level_event;
	logic rx_level_event;

	// The modem pins come from outside the clock domain and are synchronised first.
	// They reset to the inactive level so that an idle line raises nothing at release.
	// A pulse on a modem pin shorter than one clock period may be missed entirely.
	// These lines are slow handshakes, so that limitation is accepted.
	uims_sync #(
		.WIDTH(4),
		.RST_VAL(uims_pkg::MODEM_IDLE_N)
	) u_modem_sync (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.async_i(MODEM_N_I),
		.sync_o(modem_sync)
	);

	// Previous synchronised modem levels for change detection.
	// They reset idle like the synchroniser, so the release itself never looks like an edge.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			modem_prev_r <= uims_pkg::MODEM_IDLE_N;
		else
			modem_prev_r <= modem_sync;
	end

	// Any edge on a modem line is an event of its own source, in either direction.
	// A line that toggles twice before software looks still leaves one pending bit.
	assign modem_change = modem_sync ^ modem_prev_r;

	// The transmit FIFO is empty after reset, so its detector starts out already
	// below the trigger; otherwise the first cycle would raise a false interrupt.
	// A change of the trigger value while the fill stands still can also look like a passage.
	uims_cross #(
		.FILL_W(FILL_W),
		.FALLING(1'b1),
		.PREV_RST(1'b1)
	) u_tx_cross (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.fill_i(TX_FILL_I),
		.trigger_i(TX_TRIGGER_I),
		.cross_o(tx_level_event)
	);

	// The receive FIFO starts empty, below any nonzero trigger, so it starts not reached.
	// With a trigger of zero the detector fires once after reset, as the empty FIFO meets it.
	uims_cross #(
		.FILL_W(FILL_W),
		.FALLING(1'b0),
		.PREV_RST(1'b0)
	) u_rx_cross (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.fill_i(RX_FILL_I),
		.trigger_i(RX_TRIGGER_I),
		.cross_o(rx_level_event)
	);

	// Gather every event into the common source layout.
	// Error events are single-cycle pulses on this clock, so they need no synchroniser.
	always_comb
	begin
		src_event.overrun = ERR_EVENT_I.overrun;
		src_event.break_err = ERR_EVENT_I.break_err;
		src_event.parity = ERR_EVENT_I.parity;
		src_event.framing = ERR_EVENT_I.framing;
		src_event.rx_timeout = ERR_EVENT_I.rx_timeout;
		src_event.tx_level = tx_level_event;
		src_event.rx_level = rx_level_event;
		src_event.set_ready = modem_change.set_ready_n_in;
		src_event.carrier = modem_change.carrier_detect_n_in;
		src_event.clear_to_send = modem_change.clear_to_send_n_in;
		src_event.ring = modem_change.ring_indicator_n_in;
	end

	// Address decode. Writes to the two status registers decode to nothing at all.
	// Offsets are compared in full, so no register shows up again at an alias.
	always_comb
	begin
		wr_mask = 1'b0;
		wr_clear = 1'b0;
		rd_mask = 1'b0;
		rd_raw = 1'b0;
		rd_masked = 1'b0;
		if (ADDR_I == uims_pkg::OFS_ENABLE_MASK)
		begin
			wr_mask = WR_I;
			rd_mask = RD_I;
		end
		else if (ADDR_I == uims_pkg::OFS_UNMASKED_STATE)
		begin
			rd_raw = RD_I;
		end
		else if (ADDR_I == uims_pkg::OFS_MASKED_STATE)
		begin
			rd_masked = RD_I;
		end
		else if (ADDR_I == uims_pkg::OFS_INT_CLEAR)
		begin
			wr_clear = WR_I;
		end
	end

	// Clear requests take only the low source bits; reserved write bits are dropped.
	// Outside a clear write every request is zero, so no bit is cleared by accident.
	always_comb
	begin
		if (wr_clear)
			interrupt_clear = WDATA_I[uims_pkg::SRC_N-1:0];
		else
			interrupt_clear = uims_pkg::RAW_RST;
	end

	// The mask follows each written bit exactly, one sets and zero clears.
	// Reserved write bits are dropped, since software must leave them unchanged anyway.
	always_comb
	begin
		if (wr_mask)
			interrupt_enable_mask_nxt = WDATA_I[uims_pkg::SRC_N-1:0];
		else
			interrupt_enable_mask_nxt = interrupt_enable_mask_r;
	end

	// Mask register.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			interrupt_enable_mask_r <= uims_pkg::MASK_RST;
		else
			interrupt_enable_mask_r <= interrupt_enable_mask_nxt;
	end

	// Each raw bit is sticky. An event that lands in the same cycle as its clear
	// wins, so software never loses an interrupt it had not yet seen.
	// A source whose own logic defines another clearing condition would add its term here.
	for (genvar i = 0; i < uims_pkg::SRC_N; i++)
	begin : g_raw
		assign unmasked_interrupt_state_nxt[i] = src_event[i] |
			(unmasked_interrupt_state_r[i] & ~interrupt_clear[i]);
	end

	// Raw status register. The modem bits are left free to be anything after reset,
	// but a known zero costs nothing and keeps the interrupt line quiet.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			unmasked_interrupt_state_r <= uims_pkg::RAW_RST;
		else
			unmasked_interrupt_state_r <= unmasked_interrupt_state_nxt;
	end

	// Masked state is built from the next values so that the registered copy always
	// equals the AND of the raw and mask registers in the same cycle.
	assign masked_irq_nxt = unmasked_interrupt_state_nxt & interrupt_enable_mask_nxt;

	// Masked state, which also drives the per-source interrupt lines.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			masked_irq_r <= uims_pkg::RAW_RST;
		else
			masked_irq_r <= masked_irq_nxt;
	end

	// The combined line is formed from the same next values, so it rises and falls in
	// the same cycle as the per-source lines and never disagrees with them.
	assign intr_nxt = |masked_irq_nxt;

	// Combined interrupt line towards the interrupt controller.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			intr_r <= 1'h0;
		else
			intr_r <= intr_nxt;
	end

	// Read multiplexer. The clear register and unmapped offsets read as zero, and the
	// reserved bits of every register are zero filled.
	// Only one read select can be high, as the offsets differ; the chain fixes a priority anyway.
	always_comb
	begin
		rdata_nxt = uims_pkg::RDATA_RST;
		if (rd_mask)
			rdata_nxt = {5'h00, interrupt_enable_mask_r};
		else if (rd_raw)
			rdata_nxt = {5'h00, unmasked_interrupt_state_r};
		else if (rd_masked)
			rdata_nxt = {5'h00, masked_irq_r};
	end

	// Read data stand for exactly the cycle after the read strobe.
	// Zero outside that cycle keeps a shared read bus quiet without a separate enable.
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			rdata_r <= uims_pkg::RDATA_RST;
		else
			rdata_r <= rdata_nxt;
	end

	// All outputs come straight from flops.
	// No combinational path runs from the bus or the event inputs to any output.
	assign RDATA_O = rdata_r;
	assign IRQ_O = masked_irq_r;
	assign INTR_O = intr_r;

endmodule : uims_top

// ### dv/uims_chk_assertions.sv
`timescale 1ns/1ns
// Watches the register port and the interrupt outputs.
module uims_chk (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [uims_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [uims_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [uims_pkg::DATA_W-1:0] RDATA_O,
	input wire uims_pkg::uims_err_s ERR_EVENT_I,
	input wire uims_pkg::uims_src_s IRQ_O,
	input wire logic INTR_O
);
	logic wm;
	logic wc;
	// Decoded write strobes keep the properties short.
	assign wm = WR_I && ADDR_I == uims_pkg::OFS_ENABLE_MASK;
	assign wc = WR_I && ADDR_I == uims_pkg::OFS_INT_CLEAR;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	a_rsvd_zero: assert property (RD_I |=> RDATA_O[15:11] == 5'h00)
		else $error("Reserved read bits not zero.");
	a_masked_read: assert property (RD_I && ADDR_I == uims_pkg::OFS_MASKED_STATE
		|=> RDATA_O == {5'h00, $past(IRQ_O)})
		else $error("Masked status read differs from outputs.");
	a_raw_read: assert property (RD_I && ADDR_I == uims_pkg::OFS_UNMASKED_STATE
		|=> (RDATA_O[10:0] & $past(IRQ_O)) == $past(IRQ_O))
		else $error("Raw status lacks an active output bit.");
	a_intr_any: assert property (INTR_O == (IRQ_O != 11'h000))
		else $error("Summary interrupt not the OR of outputs.");
	a_irq_sticky: assert property ($fell(IRQ_O.overrun)
		|-> $past(wc && WDATA_I[10] || wm && !WDATA_I[10]))
		else $error("Overrun output dropped with no clear.");
	a_irq_rise: assert property ($rose(IRQ_O.framing)
		|-> $past(ERR_EVENT_I.framing || wm && WDATA_I[7]))
		else $error("Framing output rose with no cause.");
	a_clear_bit: assert property (wc && WDATA_I[9] && !ERR_EVENT_I.break_err
		|=> !IRQ_O.break_err)
		else $error("Break output survived its clear.");
	a_mask_off: assert property (wm && WDATA_I[10:0] == 11'h000
		|=> IRQ_O == 11'h000 && !INTR_O)
		else $error("Output active with all masks off.");
endmodule : uims_chk

bind uims_top uims_chk u_chk (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.ERR_EVENT_I(ERR_EVENT_I), .IRQ_O(IRQ_O), .INTR_O(INTR_O));

// ### dv/uims_intc.sv
`timescale 1ns/1ns
// Interrupt controller stand-in that counts assertions of the level line.
module uims_intc (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic intr_i,
	output int rise_o
);
	logic last_r;
	// A level stays high until served, so only its rising edge counts once.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			last_r <= 1'b0;
			rise_o <= 0;
		end
		else
		begin
			last_r <= intr_i;
			if (intr_i && !last_r)
				rise_o <= rise_o + 1;
		end
	end
endmodule : uims_intc

// ### dv/tb_top.sv
`timescale 1ns/1ns
// Register-level bench for the interrupt mask and status block.
module tb_top;
	localparam logic [11:0] msk_a = uims_pkg::OFS_ENABLE_MASK;
	localparam logic [11:0] raw_a = uims_pkg::OFS_UNMASKED_STATE;
	localparam logic [11:0] mis_a = uims_pkg::OFS_MASKED_STATE;
	localparam logic [11:0] clr_a = uims_pkg::OFS_INT_CLEAR;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [4:0] err = 5'h00;
	logic [5:0] txf = 6'h00;
	logic [5:0] rxf = 6'h00;
	logic [3:0] modem = 4'hF;
	logic [15:0] rdata;
	uims_pkg::uims_src_s irq;
	logic intr;
	int rises;
	int err_total = 0;
	int cmp_count = 0;
	// Free-running 10 MHz clock.
	always #50 clk = ~clk;
	uims_top DUT (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ERR_EVENT_I(err), .TX_FILL_I(txf),
		.TX_TRIGGER_I(6'h04), .RX_FILL_I(rxf), .RX_TRIGGER_I(6'h08), .MODEM_N_I(modem),
		.IRQ_O(irq), .INTR_O(intr));
	uims_intc u_intc (.clk_i(clk), .rst_n_i(rst_n), .intr_i(intr), .rise_o(rises));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stands only in the cycle after the strobe, so it is sampled there.
	task automatic rd_chk(input string n, input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rd_chk
	task automatic rs(input logic [15:0] r, input logic [15:0] m);
		rd_chk("raw", raw_a, r);
		rd_chk("masked", mis_a, m);
	endtask : rs
	task automatic pulse(input logic [4:0] e);
		@(posedge clk);
		err <= e;
		@(posedge clk);
		err <= 5'h00;
	endtask : pulse
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// The modem path has a synchroniser, so its event is awaited with a bound.
	// One edge passes first and each look falls just after an edge, so the line
	// still standing from a just-cleared event is never taken for the new one.
	task automatic wait_intr();
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (intr !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (intr !== 1'b1)
		begin
			err_total++;
			finish_test();
		end
	endtask : wait_intr
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("mask", msk_a, 16'h0000);
		rs(16'h0000, 16'h0000);
		wr_reg(msk_a, 16'h07FF);
		rd_chk("mask", msk_a, 16'h07FF);
		wr_reg(msk_a, 16'h0000);
		rd_chk("mask", msk_a, 16'h0000);
		for (int i = 6; i < 11; i++)
		begin
			wr_reg(msk_a, 16'h0001 << i);
			pulse(5'h01 << (i - 6));
			rs(16'h0001 << i, 16'h0001 << i);
			chk("irq", 16'h0001 << i, {5'h00, irq});
			chk("intr", 16'h0001, {15'h0000, intr});
			wr_reg(clr_a, 16'h07FF ^ (16'h0001 << i));
			rd_chk("raw", raw_a, 16'h0001 << i);
			wr_reg(clr_a, 16'h0001 << i);
			rs(16'h0000, 16'h0000);
		end
		wr_reg(msk_a, 16'h0000);
		pulse(5'h02);
		wr_reg(raw_a, 16'h0000);
		wr_reg(mis_a, 16'h07FF);
		rs(16'h0080, 16'h0000);
		wr_reg(msk_a, 16'h0080);
		rd_chk("masked", mis_a, 16'h0080);
		rd_chk("clear", clr_a, 16'h0000);
		wr_reg(clr_a, 16'h07FF);
		wr_reg(msk_a, 16'h0030);
		@(posedge clk);
		rxf <= 6'h08;
		repeat (2) @(posedge clk);
		rs(16'h0010, 16'h0010);
		wr_reg(clr_a, 16'h0010);
		rxf <= 6'h09;
		@(posedge clk);
		txf <= 6'h0A;
		repeat (2) @(posedge clk);
		rd_chk("raw", raw_a, 16'h0000);
		@(posedge clk);
		txf <= 6'h04;
		repeat (2) @(posedge clk);
		rd_chk("raw", raw_a, 16'h0020);
		wr_reg(clr_a, 16'h07FF);
		wr_reg(msk_a, 16'h000F);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			modem[k] <= 1'b0;
			wait_intr();
			rd_chk("raw", raw_a, 16'h0001 << k);
			chk("irq", 16'h0001 << k, {5'h00, irq});
			wr_reg(clr_a, 16'h0001 << k);
			modem[k] <= 1'b1;
			wait_intr();
			wr_reg(clr_a, 16'h0001 << k);
		end
		repeat (2) @(posedge clk);
		chk("rises", 16'h0010, 16'(rises));
		finish_test();
	end
endmodule : tb_top
